// ===== core/typec_consts.vh
// Constants for the Type-C source attach controller.
// Assumes inclusion by bare name from the design file; definitions only.
// Function
// - Watch both CC pins for attach, orientation.
// - Same pins: advertise, VCONN routing, accessory detect.
// - Ra on one pin only: everything off.
// - Rd plus Ra: VBUS on, attached low, VCONN.
// - Orientation low for Rd on second pin.
// - Rd both: debug low, VBUS off, CC1 detach.
// - Ra both: audio low, all off, CC2 detach.
// - Flags open-drain; system supplies pull-ups.
// - Straps pick default, 1.5A or 3A advertisement.
// - Current limit 1.7A, or 3.4A at 3A.
// - Load detect only at 3A, 1.95A threshold.
// - Overload holds VBUS and VCONN at limits.
// - Enabled into short: ramp, hold at limit.
// - Hot while limiting: switch off.
// - Restart after cooling hysteresis; repeat while overloaded.
`ifndef TYPEC_CONSTS_VH
`define TYPEC_CONSTS_VH
// CC pin termination codes
`define TERM_OPEN 2'h0
`define TERM_RD 2'h1
`define TERM_RA 2'h2
// Advertisement level codes
`define ADV_DEFAULT 2'h0
`define ADV_1A5 2'h1
`define ADV_3A 2'h2
// Current limit select codes
`define ILIM_LOW 1'h0
`define ILIM_HIGH 1'h1
// Current ramp step counts
`define RAMP_STEPS 4'hf
`define RAMP_ZERO 4'h0
`define RAMP_INC 4'h1
// Wishbone register byte offsets
`define REG_STATUS 4'h0
`define REG_MASK 4'h4
`define REG_STATE 4'h8
`define REG_CTRL 4'hc
// Event bits: attach, detach, thermal trip, overload, heavy load
`define EV_WIDTH 5
`define EV_ATTACH 0
`define EV_DETACH 1
`define EV_THERM 2
`define EV_OVL 3
`define EV_LOAD 4
`define CTRL_EN 0
`define CTRL_RESET 1'h1
`endif

// ===== core/typec_source_attach_control.v
// Attach classification, power steering, advertisement and thermal cycling.
// Assumes synchronous comparator and thermal inputs; Wishbone classic slave.
`timescale 1ns/100ps
`include "typec_consts.vh"
module typec_source_attach_control (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] cc1_term_i,
    input wire [1:0] cc2_term_i,
    input wire adv_level_strap_i,
    input wire adv_high_strap_i,
    input wire overcurrent_i,
    input wire load_above_thresh_i,
    input wire temp_trip_i,
    input wire temp_cooled_i,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg vbus_switch_en_o,
    output reg vconn_cc1_en_o,
    output reg vconn_cc2_en_o,
    output reg [1:0] adv_level_o,
    output reg ilim_sel_o,
    output reg load_detect_en_o,
    output reg [3:0] ilim_ramp_o,
    output wire orientation_flag_n_o,
    output wire orientation_flag_n_oe_o,
    output wire sink_attached_n_o,
    output wire sink_attached_n_oe_o,
    output wire audio_flag_n_o,
    output wire audio_flag_n_oe_o,
    output wire debug_flag_n_o,
    output wire debug_flag_n_oe_o,
    output wire heavy_load_flag_n_o,
    output wire heavy_load_flag_n_oe_o,
    output wire irq_o
);
    // One-hot attach states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_SINK = 5'h02;
    localparam [4:0] ST_DEBUG = 5'h04;
    localparam [4:0] ST_AUDIO = 5'h08;
    localparam [4:0] ST_CABLE = 5'h10;
    // Thermal states
    localparam [2:0] TH_RUN = 3'h1;
    localparam [2:0] TH_OFF = 3'h2;
    localparam [2:0] TH_WAIT = 3'h4;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg orient_rev_q;
    reg orient_rev_d;
    reg vconn_on_cc1_q;
    reg vconn_on_cc1_d;
    reg vconn_on_cc2_q;
    reg vconn_on_cc2_d;
    reg [2:0] therm_q;
    reg [2:0] therm_d;
    reg [`EV_WIDTH-1:0] status_q;
    reg [`EV_WIDTH-1:0] mask_q;
    reg enable_q;
    reg attached_q;
    reg heavy_load_q;
    wire [`EV_WIDTH-1:0] events;
    wire bus_req;
    wire wr_now;
    wire sink_next;
    wire power_ok;
    wire strap_high;
    wire [3:0] ramp_next;
    wire [31:0] state_word;

    // Decoding used for both pins
    function is_rd;
        input [1:0] term;
        begin
            is_rd = (term == `TERM_RD);
        end
    endfunction

    function is_ra;
        input [1:0] term;
        begin
            is_ra = (term == `TERM_RA);
        end
    endfunction

    // Attach classification from the two CC terminations
    // Accessories take priority over a lone sink or cable
    always @* begin
        state_d = state_q;
        orient_rev_d = orient_rev_q;
        vconn_on_cc1_d = vconn_on_cc1_q;
        vconn_on_cc2_d = vconn_on_cc2_q;
        case (state_q)
            ST_IDLE, ST_CABLE: begin
                vconn_on_cc1_d = 1'b0;
                vconn_on_cc2_d = 1'b0;
                orient_rev_d = 1'b0;
                if (is_rd(cc1_term_i) && is_rd(cc2_term_i)) begin
                    state_d = ST_DEBUG;
                end else if (is_ra(cc1_term_i) && is_ra(cc2_term_i)) begin
                    state_d = ST_AUDIO;
                end else if (is_rd(cc1_term_i) || is_rd(cc2_term_i)) begin
                    state_d = ST_SINK;
                    orient_rev_d = is_rd(cc2_term_i);
                    vconn_on_cc1_d = is_ra(cc1_term_i);
                    vconn_on_cc2_d = is_ra(cc2_term_i);
                end else if (is_ra(cc1_term_i) || is_ra(cc2_term_i)) begin
                    // Cable alone: stay unpowered, a sink may still follow
                    state_d = ST_CABLE;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SINK: begin
                // Detach when Rd leaves the pin it was found on
                if (orient_rev_q ? !is_rd(cc2_term_i) : !is_rd(cc1_term_i)) begin
                    state_d = ST_IDLE;
                    vconn_on_cc1_d = 1'b0;
                    vconn_on_cc2_d = 1'b0;
                    orient_rev_d = 1'b0;
                end
            end
            ST_DEBUG: begin
                if (!is_rd(cc1_term_i)) begin
                    state_d = ST_IDLE;
                end
            end
            ST_AUDIO: begin
                if (!is_ra(cc2_term_i)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                // Broken one-hot code: fall back to idle
                state_d = ST_IDLE;
            end
        endcase
        // Disable overrides everything, as if the port were open
        if (!enable_q) begin
            state_d = ST_IDLE;
            orient_rev_d = 1'b0;
            vconn_on_cc1_d = 1'b0;
            vconn_on_cc2_d = 1'b0;
        end
    end

    // Thermal cycling: trip only while limiting, restart after cooling
    always @* begin
        therm_d = therm_q;
        case (therm_q)
            TH_RUN: begin
                if (overcurrent_i && temp_trip_i) begin
                    therm_d = TH_OFF;
                end
            end
            TH_OFF: begin
                if (temp_cooled_i) begin
                    therm_d = TH_WAIT;
                end
            end
            TH_WAIT: begin
                therm_d = TH_RUN;
            end
            default: begin
                // Broken code: recover to run
                therm_d = TH_RUN;
            end
        endcase
    end

    // State registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            orient_rev_q <= 1'b0;
            vconn_on_cc1_q <= 1'b0;
            vconn_on_cc2_q <= 1'b0;
            therm_q <= TH_RUN;
        end else begin
            state_q <= state_d;
            orient_rev_q <= orient_rev_d;
            vconn_on_cc1_q <= vconn_on_cc1_d;
            vconn_on_cc2_q <= vconn_on_cc2_d;
            therm_q <= therm_d;
        end
    end

    // Shared qualifiers; VBUS and the ramp must agree cycle for cycle
    assign sink_next = (state_d == ST_SINK);
    assign power_ok = sink_next && (therm_d == TH_RUN);
    assign strap_high = adv_level_strap_i && adv_high_strap_i;
    assign ramp_next = ilim_ramp_o + `RAMP_INC; // Used only below the top step, so no wrap

    // Power steering, advertisement and current limit outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            vbus_switch_en_o <= 1'b0;
            vconn_cc1_en_o <= 1'b0;
            vconn_cc2_en_o <= 1'b0;
            adv_level_o <= `ADV_DEFAULT;
            ilim_sel_o <= `ILIM_LOW;
            load_detect_en_o <= 1'b0;
            ilim_ramp_o <= `RAMP_ZERO;
            attached_q <= 1'b0;
            heavy_load_q <= 1'b0;
        end else begin
            // Switch off on thermal trip; VBUS only for a sink
            vbus_switch_en_o <= power_ok;
            vconn_cc1_en_o <= vconn_on_cc1_d && (therm_d == TH_RUN);
            vconn_cc2_en_o <= vconn_on_cc2_d && (therm_d == TH_RUN);
            attached_q <= sink_next;
            if (strap_high) begin
                adv_level_o <= `ADV_3A;
                ilim_sel_o <= `ILIM_HIGH;
                load_detect_en_o <= 1'b1;
            end else begin
                adv_level_o <= adv_level_strap_i ? `ADV_1A5 : `ADV_DEFAULT;
                ilim_sel_o <= `ILIM_LOW;
                load_detect_en_o <= 1'b0;
            end
            // Heavy-load flag only means something at the 3A level
            heavy_load_q <= load_above_thresh_i && strap_high && sink_next;
            // Ramp up to the limit from zero after each switch-on, hold while overloaded
            if (!power_ok) begin
                ilim_ramp_o <= `RAMP_ZERO;
            end else if (ilim_ramp_o != `RAMP_STEPS) begin
                ilim_ramp_o <= ramp_next;
            end // Holds at full limit under overload
        end
    end

    // Open-drain flags: output data always low, enable pulls the pin down
    assign sink_attached_n_o = 1'b0;
    assign orientation_flag_n_o = 1'b0;
    assign audio_flag_n_o = 1'b0;
    assign debug_flag_n_o = 1'b0;
    assign heavy_load_flag_n_o = 1'b0;
    assign sink_attached_n_oe_o = attached_q;
    assign orientation_flag_n_oe_o = (state_q == ST_SINK) && orient_rev_q;
    assign audio_flag_n_oe_o = (state_q == ST_AUDIO);
    assign debug_flag_n_oe_o = (state_q == ST_DEBUG);
    assign heavy_load_flag_n_oe_o = heavy_load_q;

    // Event sources: attach, detach and thermal are pulses; overload and heavy load are levels
    // Detach also fires when software disables the port
    assign events[`EV_ATTACH] = (state_d == ST_SINK) && (state_q != ST_SINK);
    assign events[`EV_DETACH] = (state_q == ST_SINK) && (state_d != ST_SINK);
    assign events[`EV_THERM] = (therm_q == TH_RUN) && (therm_d == TH_OFF);
    assign events[`EV_OVL] = overcurrent_i && (state_q == ST_SINK);
    assign events[`EV_LOAD] = heavy_load_q;

    // Read view of the attach state; a cable alone shows no state bit
    assign state_word = {22'h000000, orient_rev_q, therm_q, adv_level_o, state_q[3:0]};

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_now = bus_req && wb_we_i && wb_sel_i[0];

    // Wishbone slave: one wait state, ack one cycle after request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            status_q <= {`EV_WIDTH{1'b0}};
            mask_q <= {`EV_WIDTH{1'b0}};
            enable_q <= `CTRL_RESET;
        end else begin
            wb_ack_o <= bus_req;
            // Set wins over write-one-to-clear so no event is lost
            if (wr_now && (wb_adr_i == `REG_STATUS)) begin
                status_q <= (status_q & ~wb_dat_i[`EV_WIDTH-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
            if (wr_now && (wb_adr_i == `REG_MASK)) begin
                mask_q <= wb_dat_i[`EV_WIDTH-1:0];
            end
            if (wr_now && (wb_adr_i == `REG_CTRL)) begin
                enable_q <= wb_dat_i[`CTRL_EN];
            end
            // Read data stands only in the ack cycle
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `REG_STATUS: wb_dat_o <= {{(32-`EV_WIDTH){1'b0}}, status_q};
                    `REG_MASK: wb_dat_o <= {{(32-`EV_WIDTH){1'b0}}, mask_q};
                    `REG_STATE: wb_dat_o <= state_word;
                    `REG_CTRL: wb_dat_o <= {31'h00000000, enable_q};
                    // Unmapped offsets read zero but are still acked
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Level interrupt while any unmasked event is pending
    assign irq_o = |(status_q & mask_q);

endmodule // typec_source_attach_control

// ===== dv/typec_attach_checker.sv
// Checker for attach steering, advertisement and thermal cycling.
// Assumes binding onto the top module; one clock, synchronous reset.
`timescale 1ns/100ps
`include "typec_consts.vh"
module typec_attach_checker (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] cc1_term_i,
    input wire [1:0] cc2_term_i,
    input wire adv_level_strap_i,
    input wire adv_high_strap_i,
    input wire overcurrent_i,
    input wire temp_trip_i,
    input wire temp_cooled_i,
    input wire vbus_switch_en_o,
    input wire vconn_cc1_en_o,
    input wire vconn_cc2_en_o,
    input wire [1:0] adv_level_o,
    input wire ilim_sel_o,
    input wire load_detect_en_o,
    input wire [3:0] ilim_ramp_o,
    input wire orientation_flag_n_oe_o,
    input wire sink_attached_n_oe_o,
    input wire audio_flag_n_oe_o,
    input wire debug_flag_n_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire both_open = cc1_term_i == `TERM_OPEN && cc2_term_i == `TERM_OPEN;
    wire [1:0] adv_exp = adv_level_strap_i ? (adv_high_strap_i ? `ADV_3A : `ADV_1A5) : `ADV_DEFAULT;
    // Steering outputs tied to the classification that caused them
    property p_idle; both_open [*2] |=> !vbus_switch_en_o && !vconn_cc1_en_o && !vconn_cc2_en_o
        && !sink_attached_n_oe_o && !orientation_flag_n_oe_o && !audio_flag_n_oe_o && !debug_flag_n_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("outputs active with both pins open");
    property p_orient; $rose(sink_attached_n_oe_o) |-> orientation_flag_n_oe_o == ($past(cc2_term_i) == `TERM_RD); endproperty
    a_orient: assert property (p_orient) else $error("orientation flag wrong at attach");
    property p_vconn; $rose(vbus_switch_en_o) |-> vconn_cc1_en_o == ($past(cc1_term_i) == `TERM_RA)
        && vconn_cc2_en_o == ($past(cc2_term_i) == `TERM_RA); endproperty
    a_vconn: assert property (p_vconn) else $error("vconn on wrong pin");
    property p_debug; debug_flag_n_oe_o |-> !vbus_switch_en_o; endproperty
    a_debug: assert property (p_debug) else $error("vbus on with debug accessory");
    property p_audio; audio_flag_n_oe_o |-> !vbus_switch_en_o && !vconn_cc1_en_o && !vconn_cc2_en_o; endproperty
    a_audio: assert property (p_audio) else $error("power on with audio accessory");
    // Straps are level inputs, so a stable pair must show its advertisement
    property p_adv; !$past(rst_i) && $stable({adv_level_strap_i, adv_high_strap_i}) |-> adv_level_o == adv_exp; endproperty
    a_adv: assert property (p_adv) else $error("advertisement level mismatch");
    property p_ilim; ilim_sel_o == (adv_level_o == `ADV_3A) && load_detect_en_o == ilim_sel_o; endproperty
    a_ilim: assert property (p_ilim) else $error("limit or load detect mismatch");
    property p_ramp; vbus_switch_en_o |=> !vbus_switch_en_o
        || ilim_ramp_o == ($past(ilim_ramp_o) == `RAMP_STEPS ? `RAMP_STEPS : $past(ilim_ramp_o) + 4'h1); endproperty
    a_ramp: assert property (p_ramp) else $error("current ramp step wrong");
    property p_trip; vbus_switch_en_o && overcurrent_i && temp_trip_i |=> !vbus_switch_en_o && ilim_ramp_o == `RAMP_ZERO; endproperty
    a_trip: assert property (p_trip) else $error("switch stayed on when hot");
    property p_restart; sink_attached_n_oe_o && !vbus_switch_en_o && temp_cooled_i && !temp_trip_i
        |-> ##[1:3] (vbus_switch_en_o || !sink_attached_n_oe_o); endproperty
    a_restart: assert property (p_restart) else $error("no restart after cooling");
    c_debug: cover property ($rose(debug_flag_n_oe_o));
    c_audio: cover property ($rose(audio_flag_n_oe_o));
    c_trip: cover property ($fell(vbus_switch_en_o) && temp_trip_i);
endmodule // typec_attach_checker
bind typec_source_attach_control typec_attach_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .cc1_term_i(cc1_term_i), .cc2_term_i(cc2_term_i), .adv_level_strap_i(adv_level_strap_i),
    .adv_high_strap_i(adv_high_strap_i), .overcurrent_i(overcurrent_i), .temp_trip_i(temp_trip_i),
    .temp_cooled_i(temp_cooled_i), .vbus_switch_en_o(vbus_switch_en_o), .vconn_cc1_en_o(vconn_cc1_en_o),
    .vconn_cc2_en_o(vconn_cc2_en_o), .adv_level_o(adv_level_o), .ilim_sel_o(ilim_sel_o),
    .load_detect_en_o(load_detect_en_o), .ilim_ramp_o(ilim_ramp_o),
    .orientation_flag_n_oe_o(orientation_flag_n_oe_o), .sink_attached_n_oe_o(sink_attached_n_oe_o),
    .audio_flag_n_oe_o(audio_flag_n_oe_o), .debug_flag_n_oe_o(debug_flag_n_oe_o));

// ===== dv/typec_far_end.sv
// Far-end model: sink, cable or accessory terminations on both CC pins.
// Assumes kind_i is changed by the bench just after a rising clock edge.
`timescale 1ns/100ps
`include "typec_consts.vh"
module typec_far_end (
    input wire logic [3:0] kind_i,
    input wire logic [4:0] oe_i,
    input wire logic [4:0] od_i,
    output logic [1:0] cc1_o,
    output logic [1:0] cc2_o,
    output logic [4:0] level_o
);
    // Attachment kinds: 1-2 sink, 3-4 cable only, 5-6 cable and sink, 7 debug, 8 audio
    always_comb begin
        case (kind_i)
            4'h1: {cc1_o, cc2_o} = {`TERM_RD, `TERM_OPEN};
            4'h2: {cc1_o, cc2_o} = {`TERM_OPEN, `TERM_RD};
            4'h3: {cc1_o, cc2_o} = {`TERM_OPEN, `TERM_RA};
            4'h4: {cc1_o, cc2_o} = {`TERM_RA, `TERM_OPEN};
            4'h5: {cc1_o, cc2_o} = {`TERM_RD, `TERM_RA};
            4'h6: {cc1_o, cc2_o} = {`TERM_RA, `TERM_RD};
            4'h7: {cc1_o, cc2_o} = {`TERM_RD, `TERM_RD};
            4'h8: {cc1_o, cc2_o} = {`TERM_RA, `TERM_RA};
            default: {cc1_o, cc2_o} = {`TERM_OPEN, `TERM_OPEN};
        endcase
    end
    // Pull-ups on every open-drain flag; the line only goes low when driven
    assign level_o = (oe_i & od_i) | ~oe_i;
endmodule // typec_far_end

// ===== dv/typec_source_attach_control_tb_top.sv
// Testbench: attachment table, straps, thermal cycling and Wishbone registers.
// Assumes the far-end model drives CC terminations and resolves pulled-up flags.
`timescale 1ns/100ps
`include "typec_consts.vh"
module typec_source_attach_control_tb_top;
    logic clk_i, rst_i, lvl, hi, ovc, ld, trip, cool, cyc, stb, we, ack, irq;
    logic vbus, vc1, vc2, ilim, lden;
    logic [3:0] adr, kind, ramp;
    logic [31:0] dat, dat_o, q;
    logic [1:0] cc1, cc2, adv;
    logic [4:0] oe, od, lvl_n;
    logic [6:0] exp_t [9] = '{7'h0f, 7'h4b, 7'h43, 7'h0f, 7'h0f, 7'h5b, 7'h63, 7'h0e, 7'h0d};
    int fails = 0, check_count = 0;
    typec_far_end far_u (.kind_i(kind), .oe_i(oe), .od_i(od), .cc1_o(cc1), .cc2_o(cc2), .level_o(lvl_n));
    typec_source_attach_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cc1_term_i(cc1), .cc2_term_i(cc2),
        .adv_level_strap_i(lvl), .adv_high_strap_i(hi), .overcurrent_i(ovc), .load_above_thresh_i(ld),
        .temp_trip_i(trip), .temp_cooled_i(cool), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .vbus_switch_en_o(vbus), .vconn_cc1_en_o(vc1), .vconn_cc2_en_o(vc2), .adv_level_o(adv),
        .ilim_sel_o(ilim), .load_detect_en_o(lden), .ilim_ramp_o(ramp),
        .orientation_flag_n_o(od[4]), .orientation_flag_n_oe_o(oe[4]), .sink_attached_n_o(od[3]),
        .sink_attached_n_oe_o(oe[3]), .audio_flag_n_o(od[2]), .audio_flag_n_oe_o(oe[2]),
        .debug_flag_n_o(od[1]), .debug_flag_n_oe_o(oe[1]), .heavy_load_flag_n_o(od[0]),
        .heavy_load_flag_n_oe_o(oe[0]), .irq_o(irq));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic single cycle; held until ack is sampled, then one idle cycle
    task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        adr <= a; we <= w; dat <= d; cyc <= 1'b1; stb <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task tally_and_finish;
        if (fails == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far beyond the fewer than two hundred cycles the sequence needs
    initial begin
        tick(5000);
        fails++;
        tally_and_finish;
    end
    initial begin
        {rst_i, lvl, hi, ovc, ld, trip, cool, cyc, stb, we, adr, dat, kind} = {1'b1, 49'h0};
        tick(12);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(`REG_CTRL, 1'b0, 32'h0); chk(q, 32'h1);
        wb(4'h2, 1'b0, 32'h0); chk(q, 32'h0);
        wb(`REG_MASK, 1'b1, 32'h1f);
        for (int k = 0; k < 9; k++) begin
            kind <= k[3:0]; tick(3);
            chk({vbus, vc1, vc2, lvl_n[4:1]}, exp_t[k]);
            kind <= 4'h0; tick(3);
        end
        wb(`REG_STATUS, 1'b0, 32'h0); chk(q & 32'h3, 32'h3);
        chk(irq, 1'b1);
        wb(`REG_STATUS, 1'b1, 32'h1f); chk(irq, 1'b0);
        wb(`REG_MASK, 1'b1, 32'h0); kind <= 4'h1; tick(3); chk(irq, 1'b0);
        wb(`REG_MASK, 1'b1, 32'h1); chk(irq, 1'b1);
        wb(`REG_STATUS, 1'b1, 32'h1); chk(irq, 1'b0);
        for (int s = 0; s < 4; s++) begin
            {lvl, hi} <= s[1:0]; tick(3);
            chk({adv, ilim, lden}, {(s[1] ? (s[0] ? `ADV_3A : `ADV_1A5) : `ADV_DEFAULT), {2{s == 3}}});
        end
        wb(`REG_STATE, 1'b0, 32'h0); chk(q, 32'h62);
        wb(`REG_CTRL, 1'b1, 32'h0); chk({vbus, lvl_n[3]}, 2'h1);
        wb(`REG_CTRL, 1'b1, 32'h1); chk({vbus, lvl_n[3], irq}, 3'h5);
        tick(20); chk(ramp, `RAMP_STEPS);
        ld <= 1'b1; tick(3); chk(lvl_n[0], 1'b0);
        ld <= 1'b0; ovc <= 1'b1; trip <= 1'b1; tick(2); chk({vbus, ramp}, 5'h0);
        trip <= 1'b0; cool <= 1'b1; tick(5); chk(vbus, 1'b1);
        cool <= 1'b0; trip <= 1'b1; tick(2); chk(vbus, 1'b0);
        {ovc, trip, kind} <= 6'h0; tick(3);
        kind <= 4'h7; tick(3); kind <= 4'h1; tick(3); chk(lvl_n[1], 1'b0);
        kind <= 4'h2; tick(3); chk(lvl_n[1], 1'b1);
        kind <= 4'h0; tick(3);
        kind <= 4'h8; tick(3); kind <= 4'h3; tick(3); chk(lvl_n[2], 1'b0);
        kind <= 4'h4; tick(3); chk(lvl_n[2], 1'b1);
        tally_and_finish;
    end
endmodule // typec_source_attach_control_tb_top
